// ==== common/dtec_cfg.svh ====
// constants for the dual 8-bit timer / event counter
// assumes a byte-wide special-register space with 16-bit addresses
`ifndef DTEC_CFG_SVH
`define DTEC_CFG_SVH

// register addresses
`define DTEC_ADDR_CLK_SEL 16'hFF41
`define DTEC_ADDR_MODE    16'hFF49
`define DTEC_ADDR_CMP_A   16'hFF4A
`define DTEC_ADDR_CMP_B   16'hFF4B
`define DTEC_ADDR_OUTCTL  16'hFF4F
`define DTEC_ADDR_CNT_A   16'hFF50
`define DTEC_ADDR_CNT_B   16'hFF51
`define DTEC_ADDR_P3DIR   16'hFF23

// reset values
`define DTEC_CLK_SEL_RST  8'h00
`define DTEC_MODE_RST     8'h00
`define DTEC_OUTCTL_RST   8'h00
`define DTEC_P3DIR_RST    8'hFF
`define DTEC_CNT_RST      8'h00
`define DTEC_CNT_MAX      8'hFF
`define DTEC_BYTE_ZERO    8'h00

// mode control fields
`define DTEC_MODE_RUN_A   0
`define DTEC_MODE_RUN_B   1
`define DTEC_MODE_CASCADE 2
`define DTEC_MODE_KEEP    8'h07

// output control fields
`define DTEC_OC_OUT_EN_A  0
`define DTEC_OC_INV_A     1
`define DTEC_OC_LVCLR_A   2
`define DTEC_OC_LVSET_A   3
`define DTEC_OC_OUT_EN_B  4
`define DTEC_OC_INV_B     5
`define DTEC_OC_LVCLR_B   6
`define DTEC_OC_LVSET_B   7
`define DTEC_OC_KEEP      8'h33

// port 3 direction bits of the two timer pins
`define DTEC_PIN_A        1
`define DTEC_PIN_B        2

// clock select codes
`define DTEC_SEL_FALL     4'h0
`define DTEC_SEL_RISE     4'h1
`define DTEC_SEL_DIV_LO   4'h5
`define DTEC_SEL_DIV_HI   4'hE
`define DTEC_SEL_DIV_TOP  4'hF
`define DTEC_SEL_OFFSET   4'h4
`define DTEC_TOP_SHIFT    4'hC
`define DTEC_SEL_W        4

`endif

// ==== common/dtec_pkg.sv ====
// types shared by the dual timer / event counter files
// assumes dtec_cfg.svh is on the include path
package dtec_pkg;

   // register bus request from the cpu side
   typedef struct packed {
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic        word;
      logic [7:0]  wdata;
   } dtec_bus_req_s;

   // reset-held state of the main block
   typedef struct packed {
      logic [7:0]  clk_sel;
      logic [7:0]  mode;
      logic [7:0]  outctl;
      logic [7:0]  p3dir;
      logic [7:0]  cnt_a;
      logic [7:0]  cnt_b;
      logic        lvl_a;
      logic        lvl_b;
      logic        irq_a;
      logic        irq_b;
      logic [15:0] rdata;
      logic        rvalid;
      logic [11:0] presc;
   } dtec_state_s;

   // compare registers, held without reset
   typedef struct packed {
      logic [7:0] cmp_a;
      logic [7:0] cmp_b;
   } dtec_cmp_s;

   // edge detector state of one count clock selector
   typedef struct packed {
      logic armed;
      logic prev;
   } dtec_tick_s;

endpackage

// ==== src/dtec_tick_sel.sv ====
// count clock selector of one channel: divided clock or event edge
// assumes event_in is already synchronous to clk
`timescale 1ns/1ps
`include "dtec_cfg.svh"

module dtec_tick_sel
   import dtec_pkg::*;
#(
   parameter int PRESC_W = 12
) (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rstn,
   // selection
   input  wire logic [3:0]         sel,
   input  wire logic [PRESC_W-1:0] presc,
   input  wire logic               event_in,
   // one-cycle count clock event
   output logic                    tick
);

   dtec_tick_s st_reg;
   dtec_tick_s st_next;

   // a divide-by-2^k tick fires when the low k prescaler bits are all ones
   function automatic logic div_tick(input logic [3:0] code, input logic [PRESC_W-1:0] p);
      logic [3:0] k;
      logic       hit;
      k   = (code == `DTEC_SEL_DIV_TOP) ? `DTEC_TOP_SHIFT : code - `DTEC_SEL_OFFSET;
      hit = 1'b1;
      for (int i = 0; i < PRESC_W; i++) begin
         if (i < int'(k) && !p[i]) begin
            hit = 1'b0;
         end
      end
      return hit;
   endfunction

   // edge history; armed blocks a false edge right after reset
   always_comb begin
      st_next       = st_reg;
      st_next.prev  = event_in;
      st_next.armed = 1'b1;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // [RULE_26] one tick per event
   always_comb begin
      tick = 1'b0;
      if (sel == `DTEC_SEL_FALL) begin
         tick = st_reg.armed & st_reg.prev & ~event_in;
      end else if (sel == `DTEC_SEL_RISE) begin
         tick = st_reg.armed & ~st_reg.prev & event_in;
      end else if (sel >= `DTEC_SEL_DIV_LO) begin
         tick = div_tick(sel, presc);
      end
   end

endmodule // dtec_tick_sel

// ==== src/dtec_timer.sv ====
// dual 8-bit timer / event counter with 16-bit cascade mode
// assumes a synchronous byte register port from the cpu and
// event inputs already synchronous to clk
`timescale 1ns/1ps
`include "dtec_cfg.svh"

// How it works
// [RULE_01] count equal to compare clears the count, keeps counting, pulses match irq.
// [RULE_02] match period is compare value plus one count clock periods.
// [RULE_03] low clock select nibble picks counter A clock: edges or divided clock.
// [RULE_04] high clock select nibble picks counter B clock: edges of event input B or divided clock.
// [RULE_05] software never writes the prohibited clock select codes.
// [RULE_06] software stops timers before changing clock select; it resets to zero.
// [RULE_07] compare registers take byte writes only; word writes are ignored.
// [RULE_08] cascade compare is 16 bits, compare B holding the upper byte.
// [RULE_09] reset clears both count registers to zero.
// [RULE_10] reset leaves both compare registers undefined.
// [RULE_11] compare below count lets the counter wrap through zero first.
// [RULE_12] software stops timers before writing compare data in cascade.
// [RULE_13] bytes read singly; cascade count read as one coherent word.
// [RULE_14] mode control starts, stops and picks cascade; resets to zero.
// [RULE_15] software changes cascade mode only while stopped.
// [RULE_16] in cascade the run bit of channel A alone controls counting.
// [RULE_17] output control sets or clears level flops, inversion, pin enables.
// [RULE_18] level set and clear bits always read back as zero.
// [RULE_19] software writes output control only while stopped.
// [RULE_20] software clears pin direction and latch bits to drive the pins.
// [RULE_21] port 3 direction is per pin and resets to all inputs.
// [RULE_22] cascade bit chains A overflow into B's clock, A using low nibble.
// [RULE_23] cascade full match clears both counters and pulses match irq B.
// [RULE_24] with output enabled each match toggles that channel's level flop.
// [RULE_25] in cascade an A match still pulses irq A and toggles level A.
// [RULE_26] running counters step once per selected count clock event.
module dtec_timer
   import dtec_pkg::*;
#(
   parameter int PRESC_W = 12
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // register port
   input  dtec_bus_req_s    bus_req,
   output logic [15:0]      rdata,
   output logic             rvalid,
   // external event inputs
   input  wire logic        event_in_a,
   input  wire logic        event_in_b,
   // square wave outputs and their drive enables
   output logic             square_out_a,
   output logic             square_out_a_oe,
   output logic             square_out_b,
   output logic             square_out_b_oe,
   // port 3 direction for the port logic
   output logic [7:0]       port3_direction,
   // match interrupt requests, one-cycle pulses
   output logic             match_irq_a,
   output logic             match_irq_b
);

   // ********************************************************
   // state
   // ********************************************************

   dtec_state_s r_reg;
   dtec_state_s r_next;
   dtec_cmp_s   cmp_reg;
   dtec_cmp_s   cmp_next;

   logic [1:0]  tick;
   logic [1:0]  ev_in;
   logic [7:0]  sel_code [2];

   logic        casc;
   logic        run_a;
   logic        run_b;
   logic        match_a;
   logic        match_b;
   logic        byte_wr;

   // ********************************************************
   // count clock selection
   // ********************************************************

   assign ev_in       = {event_in_b, event_in_a};
   // [RULE_03] low nibble for A
   assign sel_code[0] = {4'h0, r_reg.clk_sel[`DTEC_SEL_W-1:0]};
   // [RULE_04] high nibble for B
   assign sel_code[1] = {4'h0, r_reg.clk_sel[2*`DTEC_SEL_W-1:`DTEC_SEL_W]};

   // one selector per channel; both share the free prescaler
   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_sel
         dtec_tick_sel #(
            .PRESC_W (PRESC_W)
         ) u_sel (
            .clk      (clk),
            .rstn     (rstn),
            .sel      (sel_code[ch][`DTEC_SEL_W-1:0]),
            .presc    (r_reg.presc[PRESC_W-1:0]),
            .event_in (ev_in[ch]),
            .tick     (tick[ch])
         );
      end
   endgenerate

   // ********************************************************
   // control decode
   // ********************************************************

   // [RULE_22] cascade select bit
   assign casc    = r_reg.mode[`DTEC_MODE_CASCADE];
   assign run_a   = r_reg.mode[`DTEC_MODE_RUN_A];
   // [RULE_16] cascade runs on A's run bit only
   assign run_b   = casc ? run_a : r_reg.mode[`DTEC_MODE_RUN_B];
   assign match_a = (r_reg.cnt_a == cmp_reg.cmp_a);
   assign match_b = (r_reg.cnt_b == cmp_reg.cmp_b);
   // [RULE_07] word writes are refused
   assign byte_wr = bus_req.wr & ~bus_req.word;

   // ********************************************************
   // next state
   // ********************************************************

   always_comb begin
      r_next        = r_reg;
      cmp_next      = cmp_reg;
      r_next.irq_a  = 1'b0;
      r_next.irq_b  = 1'b0;
      r_next.rvalid = 1'b0;
      // free prescaler; wraps, which keeps every divided rate periodic
      r_next.presc  = r_reg.presc + 12'h001;

      // register writes, byte wide only
      if (byte_wr) begin
         if (bus_req.addr == `DTEC_ADDR_CLK_SEL) begin
            r_next.clk_sel = bus_req.wdata;
         end else if (bus_req.addr == `DTEC_ADDR_MODE) begin
            // [RULE_14] run and mode bits
            r_next.mode = bus_req.wdata & `DTEC_MODE_KEEP;
         end else if (bus_req.addr == `DTEC_ADDR_CMP_A) begin
            cmp_next.cmp_a = bus_req.wdata;
         end else if (bus_req.addr == `DTEC_ADDR_CMP_B) begin
            cmp_next.cmp_b = bus_req.wdata;
         end else if (bus_req.addr == `DTEC_ADDR_OUTCTL) begin
            // [RULE_18] set and clear bits are not stored
            r_next.outctl = bus_req.wdata & `DTEC_OC_KEEP;
            // [RULE_17] level flop set or clear, set wins
            if (bus_req.wdata[`DTEC_OC_LVSET_A]) begin
               r_next.lvl_a = 1'b1;
            end else if (bus_req.wdata[`DTEC_OC_LVCLR_A]) begin
               r_next.lvl_a = 1'b0;
            end
            if (bus_req.wdata[`DTEC_OC_LVSET_B]) begin
               r_next.lvl_b = 1'b1;
            end else if (bus_req.wdata[`DTEC_OC_LVCLR_B]) begin
               r_next.lvl_b = 1'b0;
            end
         end else if (bus_req.addr == `DTEC_ADDR_P3DIR) begin
            // [RULE_21] per-pin direction
            r_next.p3dir = bus_req.wdata;
         end
      end

      // ------------------------------------------------------
      // counting; a stopped counter is held at zero so that
      // starting it always begins a fresh interval
      // ------------------------------------------------------
      if (casc) begin
         if (!run_a) begin
            r_next.cnt_a = `DTEC_CNT_RST;
            r_next.cnt_b = `DTEC_CNT_RST;
         end else if (tick[0]) begin
            // [RULE_25] low byte match still flags A
            if (match_a) begin
               r_next.irq_a = 1'b1;
               if (r_reg.outctl[`DTEC_OC_OUT_EN_A]) begin
                  r_next.lvl_a = ~r_reg.lvl_a;
               end
            end
            // [RULE_08] [RULE_23] full 16-bit match
            if (match_a && match_b) begin
               r_next.cnt_a = `DTEC_CNT_RST;
               r_next.cnt_b = `DTEC_CNT_RST;
               r_next.irq_b = 1'b1;
               if (r_reg.outctl[`DTEC_OC_OUT_EN_B]) begin
                  r_next.lvl_b = ~r_reg.lvl_b;
               end
            end else begin
               // [RULE_22] A overflow clocks B
               r_next.cnt_a = r_reg.cnt_a + 8'h01;
               if (r_reg.cnt_a == `DTEC_CNT_MAX) begin
                  r_next.cnt_b = r_reg.cnt_b + 8'h01;
               end
            end
         end
      end else begin
         // channel A on its own
         if (!run_a) begin
            r_next.cnt_a = `DTEC_CNT_RST;
         end else if (tick[0]) begin
            // [RULE_01] [RULE_02] clear on match
            if (match_a) begin
               r_next.cnt_a = `DTEC_CNT_RST;
               r_next.irq_a = 1'b1;
               // [RULE_24] toggle level A
               if (r_reg.outctl[`DTEC_OC_OUT_EN_A]) begin
                  r_next.lvl_a = ~r_reg.lvl_a;
               end
            end else begin
               // [RULE_11] [RULE_26] step and wrap
               r_next.cnt_a = r_reg.cnt_a + 8'h01;
            end
         end
         // channel B on its own
         if (!run_b) begin
            r_next.cnt_b = `DTEC_CNT_RST;
         end else if (tick[1]) begin
            // [RULE_01] clear on match
            if (match_b) begin
               r_next.cnt_b = `DTEC_CNT_RST;
               r_next.irq_b = 1'b1;
               // [RULE_24] toggle level B
               if (r_reg.outctl[`DTEC_OC_OUT_EN_B]) begin
                  r_next.lvl_b = ~r_reg.lvl_b;
               end
            end else begin
               // [RULE_11] step and wrap
               r_next.cnt_b = r_reg.cnt_b + 8'h01;
            end
         end
      end

      // ------------------------------------------------------
      // reads; data is taken from the current registers so a
      // word read of the count sees both bytes of one cycle
      // ------------------------------------------------------
      if (bus_req.rd) begin
         r_next.rvalid = 1'b1;
         r_next.rdata  = 16'h0000;
         if (bus_req.addr == `DTEC_ADDR_CNT_A) begin
            // [RULE_13] coherent word or single byte
            if (bus_req.word) begin
               r_next.rdata = {r_reg.cnt_b, r_reg.cnt_a};
            end else begin
               r_next.rdata = {`DTEC_BYTE_ZERO, r_reg.cnt_a};
            end
         end else if (bus_req.addr == `DTEC_ADDR_CNT_B) begin
            r_next.rdata = {`DTEC_BYTE_ZERO, r_reg.cnt_b};
         end else if (bus_req.addr == `DTEC_ADDR_CLK_SEL) begin
            r_next.rdata = {`DTEC_BYTE_ZERO, r_reg.clk_sel};
         end else if (bus_req.addr == `DTEC_ADDR_MODE) begin
            r_next.rdata = {`DTEC_BYTE_ZERO, r_reg.mode};
         end else if (bus_req.addr == `DTEC_ADDR_CMP_A) begin
            r_next.rdata = {`DTEC_BYTE_ZERO, cmp_reg.cmp_a};
         end else if (bus_req.addr == `DTEC_ADDR_CMP_B) begin
            r_next.rdata = {`DTEC_BYTE_ZERO, cmp_reg.cmp_b};
         end else if (bus_req.addr == `DTEC_ADDR_OUTCTL) begin
            // [RULE_18] level set and clear read as zero
            r_next.rdata = {`DTEC_BYTE_ZERO, r_reg.outctl};
         end else if (bus_req.addr == `DTEC_ADDR_P3DIR) begin
            r_next.rdata = {`DTEC_BYTE_ZERO, r_reg.p3dir};
         end
      end
   end

   // ********************************************************
   // registers
   // ********************************************************

   // [RULE_09] [RULE_14] [RULE_17] [RULE_21] reset values
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r_reg         <= '0;
         r_reg.clk_sel <= `DTEC_CLK_SEL_RST;
         r_reg.mode    <= `DTEC_MODE_RST;
         r_reg.outctl  <= `DTEC_OUTCTL_RST;
         r_reg.p3dir   <= `DTEC_P3DIR_RST;
         r_reg.cnt_a   <= `DTEC_CNT_RST;
         r_reg.cnt_b   <= `DTEC_CNT_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   // [RULE_10] compare registers get no reset
   always_ff @(posedge clk) begin
      cmp_reg <= cmp_next;
   end

   // ********************************************************
   // outputs
   // ********************************************************

   // inversion bit flips pin polarity; level flop keeps its state
   assign square_out_a    = r_reg.lvl_a ^ r_reg.outctl[`DTEC_OC_INV_A];
   assign square_out_b    = r_reg.lvl_b ^ r_reg.outctl[`DTEC_OC_INV_B];
   // a pin drives only when enabled and set as output
   assign square_out_a_oe = r_reg.outctl[`DTEC_OC_OUT_EN_A] & ~r_reg.p3dir[`DTEC_PIN_A];
   assign square_out_b_oe = r_reg.outctl[`DTEC_OC_OUT_EN_B] & ~r_reg.p3dir[`DTEC_PIN_B];
   assign port3_direction = r_reg.p3dir;
   assign match_irq_a     = r_reg.irq_a;
   assign match_irq_b     = r_reg.irq_b;
   assign rdata           = r_reg.rdata;
   assign rvalid          = r_reg.rvalid;

endmodule // dtec_timer

// ==== testbench/dtec_timer_checker.sv ====
// concurrent checks on the register port and pin enables of dtec_timer
// assumes the design ports of dtec_timer and one clock domain
`timescale 1ns/1ps
`include "dtec_cfg.svh"

module dtec_timer_checker
   import dtec_pkg::*;
#(
   parameter int PRESC_W = 12
) (
   // clock and reset
   input wire logic          clk,
   input wire logic          rstn,
   // register port
   input dtec_bus_req_s      bus_req,
   input wire logic [15:0]   rdata,
   input wire logic          rvalid,
   // pins
   input wire logic          square_out_a_oe,
   input wire logic          square_out_b_oe,
   input wire logic [7:0]    port3_direction
);
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // byte read of one register
   sequence s_byte_rd(logic [15:0] a);
      bus_req.rd && !bus_req.word && bus_req.addr == a;
   endsequence

   // byte write of one register
   sequence s_byte_wr(logic [15:0] a);
      bus_req.wr && !bus_req.word && bus_req.addr == a;
   endsequence

   a_rvalid_after_rd: assert property (bus_req.rd |=> rvalid)
      else $error("read not answered in the next cycle");
   a_rvalid_has_cause: assert property (rvalid |-> $past(bus_req.rd))
      else $error("read answer without a read");
   a_byte_upper_zero: assert property (bus_req.rd && !bus_req.word |=> rdata[15:8] == 8'h00)
      else $error("byte read has a nonzero upper byte");
   a_level_bits_zero: assert property (s_byte_rd(`DTEC_ADDR_OUTCTL) |=> (rdata[7:0] & ~`DTEC_OC_KEEP) == 8'h00)
      else $error("level set or clear bit reads as one");
   a_mode_spare_zero: assert property (s_byte_rd(`DTEC_ADDR_MODE) |=> rdata[7:3] == 5'h00)
      else $error("mode control spare bits read as one");
   a_dir_write_lands: assert property (s_byte_wr(`DTEC_ADDR_P3DIR) |=> port3_direction == $past(bus_req.wdata))
      else $error("direction write not applied");
   a_word_write_drop: assert property (bus_req.wr && bus_req.word |=> $stable(port3_direction))
      else $error("word write changed a register");
   a_dir_reset_input: assert property ($rose(rstn) |-> port3_direction == `DTEC_P3DIR_RST)
      else $error("direction not all inputs after reset");
   a_oe_needs_dir: assert property ((square_out_a_oe |-> !port3_direction[`DTEC_PIN_A])
      and (square_out_b_oe |-> !port3_direction[`DTEC_PIN_B]))
      else $error("pin driven while set as input");
   c_oe_seen: cover property (square_out_a_oe);
endmodule // dtec_timer_checker

bind dtec_timer dtec_timer_checker #(.PRESC_W(PRESC_W)) i_checker (.clk(clk), .rstn(rstn), .bus_req(bus_req),
   .rdata(rdata), .rvalid(rvalid), .square_out_a_oe(square_out_a_oe), .square_out_b_oe(square_out_b_oe),
   .port3_direction(port3_direction));

// ==== testbench/dual_8bit_timer_event_counter_test.sv ====
// self-checking bench for dtec_timer: registers, intervals, events, cascade, pins
// assumes the checker is bound by its own file; one 100 MHz clock
`timescale 1ns/1ps
`include "dtec_cfg.svh"

module dual_8bit_timer_event_counter_test;
   import dtec_pkg::*;
   // ****************************************
   // signals and stimulus tables
   // ****************************************
   localparam int TIMEOUT = 95000;
   logic          clk = 1'b0;
   logic          rstn = 1'b0;
   dtec_bus_req_s bus_req = '0;
   logic          event_in_a = 1'b0;
   logic          event_in_b = 1'b0;
   logic [15:0]   rdata;
   logic [7:0]    port3_direction;
   logic          rvalid, square_out_a, square_out_a_oe, square_out_b, square_out_b_oe, match_irq_a, match_irq_b;
   logic [31:0]   rd_q[$], per_a_q[$], per_b_q[$];
   int            errors = 0, checks_done = 0, cyc = 0, last_a = 0, last_b = 0, seed = 91249;
   logic [7:0]    oc [5] = '{8'h09, 8'h05, 8'h03, 8'h90, 8'hE0};
   logic [3:0]    pins [5] = '{4'b0101, 4'b0100, 4'b0101, 4'b1010, 4'b0000};

   always #5 clk = ~clk;

   dtec_timer #(.PRESC_W(12)) i_dut (.clk(clk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata), .rvalid(rvalid),
      .event_in_a(event_in_a), .event_in_b(event_in_b), .square_out_a(square_out_a),
      .square_out_a_oe(square_out_a_oe), .square_out_b(square_out_b), .square_out_b_oe(square_out_b_oe),
      .port3_direction(port3_direction), .match_irq_a(match_irq_a), .match_irq_b(match_irq_b));

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // watcher: read answers and match periods are taken off the queues as they appear
   always @(posedge clk) begin
      cyc++;
      if (cyc >= TIMEOUT) begin
         errors++;
         tally_and_finish();
      end
      if (rvalid === 1'b1 && rd_q.size() > 0) check_val(rdata, rd_q.pop_front());
      if (match_irq_a === 1'b1) begin
         if (per_a_q.size() > 0) check_val(32'(cyc - last_a), per_a_q.pop_front());
         last_a = cyc;
      end
      if (match_irq_b === 1'b1) begin
         if (per_b_q.size() > 0) check_val(32'(cyc - last_b), per_b_q.pop_front());
         last_b = cyc;
      end
   end

   task automatic do_reset;
      @(posedge clk);
      rstn <= 1'b0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
   endtask

   // strobes are held one cycle, released at the edge that takes them
   task automatic bus_write(input logic [15:0] a, input logic [7:0] d, input logic w = 1'b0);
      @(posedge clk);
      bus_req <= '{addr: a, wr: 1'b1, rd: 1'b0, word: w, wdata: d};
      @(posedge clk);
      bus_req.wr <= 1'b0;
   endtask

   task automatic bus_read(input logic [15:0] a, input logic w, input logic [15:0] exp);
      rd_q.push_back(32'(exp));
      @(posedge clk);
      bus_req <= '{addr: a, wr: 1'b0, rd: 1'b1, word: w, wdata: 8'h00};
      @(posedge clk);
      bus_req.rd <= 1'b0;
   endtask

   // bounded wait for one match pulse; the #1 keeps queue pushes after the watcher
   task automatic wait_irq(input logic b);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while ((b ? match_irq_b : match_irq_a) !== 1'b1 && n < 20000);
      #1;
      check_val(32'(n >= 20000), 32'h0);
   endtask

   task automatic run_div(input logic [3:0] k);
      logic [7:0] na, nb;
      int         t;
      na = 8'($random(seed) & 1);
      nb = 8'($random(seed) & 1);
      t = (k == `DTEC_SEL_DIV_TOP) ? 4096 : (1 << (k - 4));
      bus_write(`DTEC_ADDR_MODE, 8'h00);
      bus_write(`DTEC_ADDR_CLK_SEL, {k, k});
      bus_write(`DTEC_ADDR_CMP_A, na);
      bus_write(`DTEC_ADDR_CMP_B, nb);
      bus_write(`DTEC_ADDR_MODE, 8'h03);
      wait_irq(1'b0);
      repeat (2) per_a_q.push_back((na + 1) * t);
      wait_irq(1'b1);
      repeat (2) per_b_q.push_back((nb + 1) * t);
      while (per_a_q.size() + per_b_q.size() > 0) @(posedge clk);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      logic [7:0] d, na;
      int         e, n;
      logic       s;
      do_reset();
      bus_read(`DTEC_ADDR_CLK_SEL, 1'b0, 16'h0000);
      bus_read(`DTEC_ADDR_MODE, 1'b0, 16'h0000);
      bus_read(`DTEC_ADDR_OUTCTL, 1'b0, 16'h0000);
      bus_read(`DTEC_ADDR_P3DIR, 1'b0, 16'h00FF);
      bus_read(`DTEC_ADDR_CNT_A, 1'b1, 16'h0000);
      bus_read(16'h1234, 1'b0, 16'h0000);
      $display("test reset values done");
      repeat (4) begin
         d = 8'($random(seed));
         bus_write(`DTEC_ADDR_P3DIR, d);
         bus_write(`DTEC_ADDR_P3DIR, ~d, 1'b1);
         bus_read(`DTEC_ADDR_P3DIR, 1'b0, {8'h00, d});
         bus_write(`DTEC_ADDR_CLK_SEL, d | 8'h55);
         bus_read(`DTEC_ADDR_CLK_SEL, 1'b0, {8'h00, d | 8'h55});
         bus_write(`DTEC_ADDR_MODE, d);
         bus_read(`DTEC_ADDR_MODE, 1'b0, {8'h00, d & `DTEC_MODE_KEEP});
         bus_write(`DTEC_ADDR_MODE, 8'h00);
      end
      bus_write(`DTEC_ADDR_CNT_B, 8'h5A);
      bus_read(`DTEC_ADDR_CNT_B, 1'b0, 16'h0000);
      $display("test register access done");
      // interval periods for every divide code
      for (int k = 5; k < 16; k++) run_div(4'(k));
      $display("test interval periods done");
      // event edges: A falling, B rising
      bus_write(`DTEC_ADDR_MODE, 8'h00);
      bus_write(`DTEC_ADDR_CLK_SEL, 8'h10);
      bus_write(`DTEC_ADDR_CMP_A, 8'hFF);
      bus_write(`DTEC_ADDR_CMP_B, 8'hFF);
      bus_write(`DTEC_ADDR_MODE, 8'h03);
      e = 3 + ($random(seed) & 7);
      repeat (e) begin
         @(posedge clk);
         event_in_a <= 1'b1;
         event_in_b <= 1'b1;
         repeat (2) @(posedge clk);
         event_in_a <= 1'b0;
         event_in_b <= 1'b0;
         repeat (2) @(posedge clk);
      end
      repeat (3) @(posedge clk);
      bus_read(`DTEC_ADDR_CNT_A, 1'b1, {8'(e), 8'(e)});
      $display("test event counting done");
      bus_write(`DTEC_ADDR_MODE, 8'h00);
      bus_write(`DTEC_ADDR_CLK_SEL, 8'h55);
      bus_write(`DTEC_ADDR_CMP_A, 8'h80);
      bus_write(`DTEC_ADDR_MODE, 8'h01);
      repeat (130) @(posedge clk);
      bus_write(`DTEC_ADDR_CMP_A, 8'h10);
      n = 0;
      repeat (300) begin
         @(posedge clk);
         if (match_irq_a === 1'b1) n++;
      end
      check_val(32'(n), 32'h0);
      wait_irq(1'b0);
      $display("test compare lowered done");
      // level flops, inversion and pin enables while stopped
      bus_write(`DTEC_ADDR_MODE, 8'h00);
      bus_write(`DTEC_ADDR_P3DIR, 8'hF9);
      foreach (oc[i]) begin
         bus_write(`DTEC_ADDR_OUTCTL, oc[i]);
         bus_read(`DTEC_ADDR_OUTCTL, 1'b0, {8'h00, oc[i] & `DTEC_OC_KEEP});
         @(posedge clk);
         #1;
         check_val({square_out_b_oe, square_out_a_oe, square_out_b, square_out_a}, pins[i]);
      end
      $display("test output control done");
      // cascade after a reset with the timers stopped
      do_reset();
      na = 8'($random(seed) & 8'h0F);
      bus_write(`DTEC_ADDR_CLK_SEL, 8'h05);
      bus_write(`DTEC_ADDR_CMP_A, na);
      bus_write(`DTEC_ADDR_CMP_B, 8'h01);
      bus_write(`DTEC_ADDR_P3DIR, 8'hF9);
      bus_write(`DTEC_ADDR_OUTCTL, 8'h01);
      bus_write(`DTEC_ADDR_MODE, 8'h05);
      s = square_out_a;
      wait_irq(1'b0);
      repeat (2) @(posedge clk);
      #1;
      check_val(32'(square_out_a), 32'(!s));
      wait_irq(1'b1);
      repeat (2) per_b_q.push_back((256 + na + 1) * 2);
      while (per_b_q.size() > 0) @(posedge clk);
      $display("test cascade done");
      tally_and_finish();
   end
endmodule // dual_8bit_timer_event_counter_test
